// File: rtl/cs16_pkg.sv
// shared constants, opcodes, register map and helpers of the store16/stop unit
package cs16_pkg;
  // register offsets on the wishbone slave (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_D = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0C;
  localparam logic [7:0] OFS_X = 8'h10;
  localparam logic [7:0] OFS_Y = 8'h14;
  localparam logic [7:0] OFS_CCR = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // condition code bit positions
  localparam int CCR_S = 7;
  localparam int CCR_X = 6;
  localparam int CCR_I = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  // control and status bit positions
  localparam int CTRL_RUN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_STOPPED = 1;
  localparam int STAT_PSEUDO_NONMASKABLE_INTERRUPT = 2;
  localparam int STAT_IRQ = 3;
  // reset values
  localparam logic [7:0] CCR_RST = 8'hD0;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;
  // opcodes and prefixes
  localparam logic [7:0] PFX_Y = 8'h18;
  localparam logic [7:0] PFX_1A = 8'h1A;
  localparam logic [7:0] PFX_CD = 8'hCD;
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] OP_STOP = 8'hCF;
  localparam logic [7:0] OP_D_DIR = 8'hDD;
  localparam logic [7:0] OP_D_EXT = 8'hFD;
  localparam logic [7:0] OP_D_IND = 8'hED;
  localparam logic [7:0] OP_S_DIR = 8'h9F;
  localparam logic [7:0] OP_S_EXT = 8'hBF;
  localparam logic [7:0] OP_S_IND = 8'hAF;
  localparam logic [7:0] OP_X_DIR = 8'hDF;
  localparam logic [7:0] OP_X_EXT = 8'hFF;
  localparam logic [7:0] OP_X_IND = 8'hEF;
  // dummy address of the indexed idle read
  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
  // system clocks per bus cycle
  localparam int BUS_DIV = 4;
  // source register and addressing mode codes
  typedef enum logic [1:0] {SRC_D = 2'b00, SRC_SP = 2'b01, SRC_X = 2'b10, SRC_Y = 2'b11} cs16_src_e;
  typedef enum logic [1:0] {M_DIR = 2'b00, M_EXT = 2'b01, M_IDX = 2'b10, M_IDY = 2'b11} cs16_mode_e;

  // byte-enable merge of a 32-bit write into a 16-bit register
  function automatic logic [15:0] apply_sel(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    apply_sel = old;
    if (sel[0]) apply_sel[7:0] = dat[7:0];
    if (sel[1]) apply_sel[15:8] = dat[15:8];
  endfunction
endpackage

// File: rtl/cs16_busdiv.sv
// bus cycle enable divider, halted while the core is stopped
`timescale 1ns/1ps
`default_nettype none
module cs16_busdiv #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // gating
  input wire logic run,
  // one-cycle enable per bus cycle
  output logic bus_en
);
  // refuse a divider that cannot form a pulse
  if (DIV < 2) begin : g_bad_div
    $error("cs16_busdiv: DIV must be at least 2");
  end

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r; // position inside the bus cycle

  // free counter; cleared to zero when gated so the clocks really stand still
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      bus_en <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      bus_en <= 1'b0;
    end else begin
      bus_en <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule // cs16_busdiv
`default_nettype wire

// File: rtl/cs16_wbslave.sv
// classic wishbone slave: decode, ack, read mux and write strobe
`timescale 1ns/1ps
`default_nettype none
module cs16_wbslave
  import cs16_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // register values to read
  input wire logic [7:0] ctrl_v,
  input wire logic [15:0] pc_v,
  input wire logic [15:0] d_v,
  input wire logic [15:0] sp_v,
  input wire logic [15:0] x_v,
  input wire logic [15:0] y_v,
  input wire logic [7:0] ccr_v,
  input wire logic [7:0] stat_v,
  // write strobe toward the register owner
  output logic wr_en
);
  logic [31:0] rd_nxt; // read word for the addressed register

  // read mux; unmapped offsets answer zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (adr_i == OFS_CTRL) rd_nxt = {24'h00_0000, ctrl_v};
    else if (adr_i == OFS_PC) rd_nxt = {16'h0000, pc_v};
    else if (adr_i == OFS_D) rd_nxt = {16'h0000, d_v};
    else if (adr_i == OFS_SP) rd_nxt = {16'h0000, sp_v};
    else if (adr_i == OFS_X) rd_nxt = {16'h0000, x_v};
    else if (adr_i == OFS_Y) rd_nxt = {16'h0000, y_v};
    else if (adr_i == OFS_CCR) rd_nxt = {24'h00_0000, ccr_v};
    else if (adr_i == OFS_STATUS) rd_nxt = {24'h00_0000, stat_v};
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) dat_o <= rd_nxt;
    end
  end

  // write lands on the edge where the master sees ack
  assign wr_en = cyc_i && stb_i && we_i && ack_o;
endmodule // cs16_wbslave
`default_nettype wire

// File: rtl/cs16_core.sv
// 16-bit store and stop execution unit with its wishbone register file
// Function
// - stores set N, Z; clear V only
// - double store opcodes, A then B
// - indexed: idle read at FFFF, writes low
// - direct address is page zero operand
// - stop disabled acts as no-operation
// - stop halts clocks, keeps registers
// - wake on reset, pseudo-nmi, unmasked irq
// - pseudo-nmi unmasked wake goes to stacking
// - pseudo-nmi masked wake fetches next opcode
// - stop is one opcode, two reads
// - stop is one byte only unprefixed; a prefixed CF acts as a no-operation
// - stack pointer store opcodes, high first
// - index two store: high, then low
// - index two store prefixed opcodes
`timescale 1ns/1ps
`default_nettype none
module cs16_core
  import cs16_pkg::*;
#(
  parameter int DIV = BUS_DIV
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // memory bus
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  output logic MEM_RW,
  output logic MEM_CYC,
  // interrupt pins, active low
  input wire logic IRQ_N,
  input wire logic PSEUDO_NONMASKABLE_INTERRUPT_N,
  // status toward the interrupt unit
  output logic STOPPED,
  output logic PSEUDO_NONMASKABLE_INTERRUPT_STACK,
  output logic IRQ_WAKE
);
  typedef enum logic [3:0] {
    S_HALT = 4'b0000, S_FETCH = 4'b0001, S_OP2 = 4'b0010, S_OPR1 = 4'b0011,
    S_OPR2 = 4'b0100, S_IDLE = 4'b0101, S_WR_HI = 4'b0110, S_WR_LO = 4'b0111,
    S_INH2 = 4'b1000, S_STOP = 4'b1001
  } cs16_state_e;

  // decoded store: valid, source, mode
  typedef struct packed {
    logic ok;
    cs16_src_e src;
    cs16_mode_e mode;
  } cs16_dec_s;

  // store decode over prefix and opcode; anything else is not a store
  function automatic cs16_dec_s decode(input logic [7:0] pfx, input logic [7:0] op);
    decode = '{ok: 1'b1, src: SRC_D, mode: M_DIR};
    case ({pfx, op})
      {PFX_NONE, OP_D_DIR}: decode = '{1'b1, SRC_D, M_DIR};
      {PFX_NONE, OP_D_EXT}: decode = '{1'b1, SRC_D, M_EXT};
      {PFX_NONE, OP_D_IND}: decode = '{1'b1, SRC_D, M_IDX};
      {PFX_Y, OP_D_IND}: decode = '{1'b1, SRC_D, M_IDY};
      {PFX_NONE, OP_S_DIR}: decode = '{1'b1, SRC_SP, M_DIR};
      {PFX_NONE, OP_S_EXT}: decode = '{1'b1, SRC_SP, M_EXT};
      {PFX_NONE, OP_S_IND}: decode = '{1'b1, SRC_SP, M_IDX};
      {PFX_Y, OP_S_IND}: decode = '{1'b1, SRC_SP, M_IDY};
      {PFX_NONE, OP_X_DIR}: decode = '{1'b1, SRC_X, M_DIR};
      {PFX_NONE, OP_X_EXT}: decode = '{1'b1, SRC_X, M_EXT};
      {PFX_NONE, OP_X_IND}: decode = '{1'b1, SRC_X, M_IDX};
      {PFX_CD, OP_X_IND}: decode = '{1'b1, SRC_X, M_IDY};
      {PFX_Y, OP_X_DIR}: decode = '{1'b1, SRC_Y, M_DIR};
      {PFX_Y, OP_X_EXT}: decode = '{1'b1, SRC_Y, M_EXT};
      {PFX_Y, OP_X_IND}: decode = '{1'b1, SRC_Y, M_IDY};
      {PFX_1A, OP_X_IND}: decode = '{1'b1, SRC_Y, M_IDX};
      default: decode = '{1'b0, SRC_D, M_DIR};
    endcase
  endfunction

  // architectural registers
  logic run_r; // software run enable
  logic [15:0] pc_r; // next instruction-stream byte
  logic [15:0] d_r; // double accumulator, A in the high byte
  logic [15:0] sp_r; // stack pointer
  logic [15:0] x_r; // index one
  logic [15:0] y_r; // index two
  logic [7:0] ccr_r; // condition codes
  // sequencer state
  cs16_state_e state_r, state_nxt;
  logic [7:0] pfx_r, pfx_nxt; // prefix of the current instruction
  cs16_mode_e mode_r, mode_nxt; // addressing mode
  logic [7:0] hi_r, hi_nxt; // extended address high byte
  logic [15:0] ea_r, ea_nxt; // effective address
  logic [15:0] val_r, val_nxt; // snapshot of the stored register
  logic stop_r, stop_nxt; // current instruction is stop
  logic [15:0] pc_nxt;
  logic flag_upd; // store just finished, update flags
  logic go; // a new bus cycle starts
  logic [15:0] addr_nxt;
  logic [7:0] wdata_nxt;
  logic rw_nxt;
  // pin synchronisers and wake terms
  logic irq_s1, irq_s2, pseudo_nonmaskable_interrupt_s1, pseudo_nonmaskable_interrupt_s2;
  logic wake_x, wake_i;
  // register file glue
  logic bus_en, wr_en;
  logic [15:0] pc_inc;
  cs16_dec_s dec0, dec1;
  logic [7:0] stat_v;

  assign pc_inc = pc_r + 16'h0001;
  assign dec0 = decode(PFX_NONE, MEM_RDATA);
  assign dec1 = decode(pfx_r, MEM_RDATA);

  // value of a source register; read only, never written back
  function automatic logic [15:0] src_val(input cs16_src_e s, input logic [15:0] d,
                                          input logic [15:0] sp, input logic [15:0] x,
                                          input logic [15:0] y);
    case (s)
      SRC_D: src_val = d;
      SRC_SP: src_val = sp;
      SRC_X: src_val = x;
      default: src_val = y;
    endcase
  endfunction

  // bus cycle rate; gating it is how stop halts the clocks
  cs16_busdiv #(.DIV(DIV)) u_div (
    .clk(SYS_CLK),
    .nrst(NRST),
    .run(state_r != S_STOP),
    .bus_en(bus_en)
  );

  assign stat_v = {4'h0, ~irq_s2, ~pseudo_nonmaskable_interrupt_s2, state_r == S_STOP, state_r != S_HALT};

  // wishbone register access
  cs16_wbslave u_wb (
    .clk(SYS_CLK),
    .nrst(NRST),
    .cyc_i(WB_CYC_I),
    .stb_i(WB_STB_I),
    .we_i(WB_WE_I),
    .adr_i(WB_ADR_I),
    .dat_o(WB_DAT_O),
    .ack_o(WB_ACK_O),
    .ctrl_v({7'h00, run_r}),
    .pc_v(pc_r),
    .d_v(d_r),
    .sp_v(sp_r),
    .x_v(x_r),
    .y_v(y_r),
    .ccr_v(ccr_r),
    .stat_v(stat_v),
    .wr_en(wr_en)
  );

  // two-flop synchronisers for the asynchronous interrupt pins
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
      pseudo_nonmaskable_interrupt_s1 <= 1'b1;
      pseudo_nonmaskable_interrupt_s2 <= 1'b1;
    end else begin
      irq_s1 <= IRQ_N;
      irq_s2 <= irq_s1;
      pseudo_nonmaskable_interrupt_s1 <= PSEUDO_NONMASKABLE_INTERRUPT_N;
      pseudo_nonmaskable_interrupt_s2 <= pseudo_nonmaskable_interrupt_s1;
    end
  end

  // only these two sources end standby; reset acts through NRST
  assign wake_x = !pseudo_nonmaskable_interrupt_s2;
  assign wake_i = !irq_s2 && !ccr_r[CCR_I];

  // next bus cycle and sequencer step, evaluated at each bus boundary
  always_comb begin
    state_nxt = state_r;
    pfx_nxt = pfx_r;
    mode_nxt = mode_r;
    hi_nxt = hi_r;
    ea_nxt = ea_r;
    val_nxt = val_r;
    stop_nxt = stop_r;
    pc_nxt = pc_r;
    flag_upd = 1'b0;
    go = 1'b0;
    addr_nxt = pc_r;
    wdata_nxt = 8'h00;
    rw_nxt = 1'b1;
    case (state_r)
      S_HALT: begin
        if (run_r) begin
          state_nxt = S_FETCH;
          go = 1'b1;
        end
      end
      S_FETCH: begin
        pc_nxt = pc_inc;
        addr_nxt = pc_inc;
        go = 1'b1;
        pfx_nxt = PFX_NONE;
        stop_nxt = 1'b0;
        if (MEM_RDATA == PFX_Y || MEM_RDATA == PFX_1A || MEM_RDATA == PFX_CD) begin
          pfx_nxt = MEM_RDATA;
          state_nxt = S_OP2;
        end else if (MEM_RDATA == OP_STOP) begin
          // no operand byte; reached only without a prefix
          stop_nxt = 1'b1;
          state_nxt = S_INH2;
        end else if (dec0.ok) begin
          mode_nxt = dec0.mode;
          val_nxt = src_val(dec0.src, d_r, sp_r, x_r, y_r);
          state_nxt = S_OPR1;
        end else begin
          // any other opcode behaves as a two-cycle no-operation
          state_nxt = S_INH2;
        end
      end
      S_OP2: begin
        pc_nxt = pc_inc;
        addr_nxt = pc_inc;
        go = 1'b1;
        if (dec1.ok) begin
          mode_nxt = dec1.mode;
          val_nxt = src_val(dec1.src, d_r, sp_r, x_r, y_r);
          state_nxt = S_OPR1;
        end else begin
          state_nxt = S_FETCH;
        end
      end
      S_OPR1: begin
        pc_nxt = pc_inc;
        go = 1'b1;
        if (mode_r == M_DIR) begin
          ea_nxt = {8'h00, MEM_RDATA};
          addr_nxt = {8'h00, MEM_RDATA};
          wdata_nxt = val_r[15:8];
          rw_nxt = 1'b0;
          state_nxt = S_WR_HI;
        end else if (mode_r == M_EXT) begin
          hi_nxt = MEM_RDATA;
          addr_nxt = pc_inc;
          state_nxt = S_OPR2;
        end else begin
          ea_nxt = ((mode_r == M_IDX) ? x_r : y_r) + {8'h00, MEM_RDATA};
          addr_nxt = IDLE_ADDR;
          state_nxt = S_IDLE;
        end
      end
      S_OPR2: begin
        pc_nxt = pc_inc;
        go = 1'b1;
        ea_nxt = {hi_r, MEM_RDATA};
        addr_nxt = {hi_r, MEM_RDATA};
        wdata_nxt = val_r[15:8];
        rw_nxt = 1'b0;
        state_nxt = S_WR_HI;
      end
      S_IDLE: begin
        go = 1'b1;
        addr_nxt = ea_r;
        wdata_nxt = val_r[15:8];
        rw_nxt = 1'b0;
        state_nxt = S_WR_HI;
      end
      S_WR_HI: begin
        go = 1'b1;
        addr_nxt = ea_r + 16'h0001;
        wdata_nxt = val_r[7:0];
        rw_nxt = 1'b0;
        state_nxt = S_WR_LO;
      end
      S_WR_LO: begin
        flag_upd = 1'b1;
        go = run_r;
        state_nxt = run_r ? S_FETCH : S_HALT;
      end
      S_INH2: begin
        if (stop_r && !ccr_r[CCR_S]) begin
          state_nxt = S_STOP;
        end else begin
          go = run_r;
          state_nxt = run_r ? S_FETCH : S_HALT;
        end
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
  end

  // sequencer registers and bus drive; stop waits for a wake source
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= S_HALT;
      pfx_r <= PFX_NONE;
      mode_r <= M_DIR;
      hi_r <= 8'h00;
      ea_r <= 16'h0000;
      val_r <= 16'h0000;
      stop_r <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
      MEM_RW <= 1'b1;
      MEM_CYC <= 1'b0;
    end else if (state_r == S_STOP) begin
      MEM_CYC <= 1'b0;
      MEM_RW <= 1'b1;
      // the halt state restarts fetch at the byte after stop
      if (wake_x || wake_i) state_r <= S_HALT;
    end else if (bus_en) begin
      state_r <= state_nxt;
      pfx_r <= pfx_nxt;
      mode_r <= mode_nxt;
      hi_r <= hi_nxt;
      ea_r <= ea_nxt;
      val_r <= val_nxt;
      stop_r <= stop_nxt;
      MEM_CYC <= go;
      if (go) begin
        MEM_ADDR <= addr_nxt;
        MEM_WDATA <= wdata_nxt;
        MEM_RW <= rw_nxt;
      end else begin
        MEM_RW <= 1'b1;
      end
    end else begin
      MEM_CYC <= 1'b0;
    end
  end

  // wake indications toward the interrupt unit
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      STOPPED <= 1'b0;
      PSEUDO_NONMASKABLE_INTERRUPT_STACK <= 1'b0;
      IRQ_WAKE <= 1'b0;
    end else begin
      STOPPED <= (state_r == S_STOP) && !(wake_x || wake_i);
      PSEUDO_NONMASKABLE_INTERRUPT_STACK <= (state_r == S_STOP) && wake_x && !ccr_r[CCR_X];
      IRQ_WAKE <= (state_r == S_STOP) && wake_i && !(wake_x && !ccr_r[CCR_X]);
    end
  end

  // program counter: sequencer advance wins over a software write
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pc_r <= PC_RST;
    end else if (bus_en && state_r != S_STOP && pc_nxt != pc_r) begin
      pc_r <= pc_nxt;
    end else if (wr_en && WB_ADR_I == OFS_PC) begin
      pc_r <= apply_sel(pc_r, WB_DAT_I, WB_SEL_I);
    end
  end

  // source registers change only by software; stores and stop leave them alone
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      run_r <= 1'b0;
      d_r <= REG_RST;
      sp_r <= REG_RST;
      x_r <= REG_RST;
      y_r <= REG_RST;
    end else if (wr_en) begin
      if (WB_ADR_I == OFS_CTRL) begin
        if (WB_SEL_I[0]) run_r <= WB_DAT_I[CTRL_RUN];
      end else if (WB_ADR_I == OFS_D) begin
        d_r <= apply_sel(d_r, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == OFS_SP) begin
        sp_r <= apply_sel(sp_r, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == OFS_X) begin
        x_r <= apply_sel(x_r, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == OFS_Y) begin
        y_r <= apply_sel(y_r, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // condition codes; a finishing store overrides N, Z and V of a write
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ccr_r <= CCR_RST;
    end else begin
      if (wr_en && WB_ADR_I == OFS_CCR && WB_SEL_I[0]) ccr_r <= WB_DAT_I[7:0];
      if (bus_en && flag_upd) begin
        ccr_r[CCR_N] <= val_r[15];
        ccr_r[CCR_Z] <= (val_r == 16'h0000);
        ccr_r[CCR_V] <= 1'b0;
      end
    end
  end
endmodule // cs16_core
`default_nettype wire

// File: verif/cs16_core_assertions.sv
// port-level concurrent checks of the store16/stop unit
`timescale 1ns/1ps
`default_nettype none
module cs16_core_assertions
  import cs16_pkg::*;
#(
  parameter int DIV = BUS_DIV
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // memory bus
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RW,
  input wire logic MEM_CYC,
  // interrupt side
  input wire logic IRQ_N,
  input wire logic PSEUDO_NONMASKABLE_INTERRUPT_N,
  input wire logic STOPPED,
  input wire logic PSEUDO_NONMASKABLE_INTERRUPT_STACK
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // high after the first byte of a store pair; a lone write leaves it stuck
  logic wr_odd_r;
  // toggle on every write cycle
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST)
      wr_odd_r <= 1'b0;
    else if (MEM_CYC && !MEM_RW)
      wr_odd_r <= !wr_odd_r;
  end
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_stop_quiet: assert property (STOPPED |-> !MEM_CYC)
    else $error("bus cycle while stopped");
  a_idle_read: assert property (MEM_CYC && MEM_ADDR == IDLE_ADDR |-> MEM_RW)
    else $error("idle address cycle is not a read");
  // spacing written for the default divide of four
  a_cyc_gap: assert property (MEM_CYC |=> !MEM_CYC [*3])
    else $error("bus cycles closer than the divider");
  a_pair_next: assert property (MEM_CYC && !MEM_RW && !wr_odd_r |=> ##3 (MEM_CYC && !MEM_RW
    && MEM_ADDR == $past(MEM_ADDR, 4) + 16'h0001))
    else $error("second store byte not at address plus one");
  a_pseudo_nonmaskable_interrupt_wake: assert property (STOPPED && !PSEUDO_NONMASKABLE_INTERRUPT_N |-> ##[1:8] !STOPPED)
    else $error("no wake on pseudo nmi");
  a_stay_stop: assert property ((PSEUDO_NONMASKABLE_INTERRUPT_N && IRQ_N) [*3] ##0 STOPPED |=> STOPPED)
    else $error("left standby without a wake source");
  a_xstack_one: assert property (PSEUDO_NONMASKABLE_INTERRUPT_STACK |=> !PSEUDO_NONMASKABLE_INTERRUPT_STACK)
    else $error("stacking pulse too long");
endmodule // cs16_core_assertions
bind cs16_core cs16_core_assertions #(.DIV(DIV)) cs16_core_assertions_i (.SYS_CLK(SYS_CLK),
  .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .MEM_ADDR(MEM_ADDR), .MEM_RW(MEM_RW), .MEM_CYC(MEM_CYC), .IRQ_N(IRQ_N),
  .PSEUDO_NONMASKABLE_INTERRUPT_N(PSEUDO_NONMASKABLE_INTERRUPT_N), .STOPPED(STOPPED), .PSEUDO_NONMASKABLE_INTERRUPT_STACK(PSEUDO_NONMASKABLE_INTERRUPT_STACK));
`default_nettype wire

// File: verif/cs16_mem_model.sv
// behavioural memory on the core's byte bus, logging every bus cycle
`timescale 1ns/1ps
`default_nettype none
module cs16_mem_model (
  // clock
  input wire logic clk,
  // bus from the core
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rw,
  input wire logic cyc,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535]; // whole space, no wait states
  logic [24:0] trace [$]; // rw, address, write data of each cycle
  // fill with a harmless no-operation byte
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h01;
  end
  // not driven by memory during a write: show the inverse, never a stale byte
  assign rdata = rw ? mem[addr] : ~wdata;
  // log at the first clock of each cycle and commit writes
  always @(posedge clk) begin
    if (cyc) begin
      trace.push_back({rw, addr, wdata});
      if (!rw)
        mem[addr] <= wdata;
    end
  end
endmodule // cs16_mem_model
`default_nettype wire

// File: verif/cs16_core_bench.sv
// self-checking bench of the store16/stop unit
`timescale 1ns/1ps
`default_nettype none
module cs16_core_bench
  import cs16_pkg::*;
;
  logic SYS_CLK = 1'b0, NRST = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic irq_n = 1'b1, pseudo_nonmaskable_interrupt_n = 1'b1, ack, mrw, mcyc, stopped, xstack, irqw;
  logic [7:0] adr = 8'h00, mwdata, mrdata;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [15:0] maddr, pc;
  logic [24:0] exq [$]; // expected bus cycles
  int err_count = 0, tests_run = 0, cycles = 0, n_xs = 0, n_iw = 0, stp_seen = 0;
  always #2 SYS_CLK = ~SYS_CLK;
  cs16_core cs16_core_i (.SYS_CLK(SYS_CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_RDATA(mrdata), .MEM_RW(mrw),
    .MEM_CYC(mcyc), .IRQ_N(irq_n), .PSEUDO_NONMASKABLE_INTERRUPT_N(pseudo_nonmaskable_interrupt_n), .STOPPED(stopped), .PSEUDO_NONMASKABLE_INTERRUPT_STACK(xstack),
    .IRQ_WAKE(irqw));
  cs16_mem_model cs16_mem_model_i (.clk(SYS_CLK), .addr(maddr), .wdata(mwdata), .rw(mrw),
    .cyc(mcyc), .rdata(mrdata));
  // pulse counters and hang guard
  always @(posedge SYS_CLK) begin
    cycles++;
    if (xstack === 1'b1) n_xs++;
    if (irqw === 1'b1) n_iw++;
    if (stopped === 1'b1) stp_seen = 1;
    if (cycles == 20000) begin
      err_count++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // first n logged cycles against the expected list; read data is not judged
  task automatic chk_trace(input int n);
    logic [24:0] g;
    tests_run++;
    for (int i = 0; i < n; i++) begin
      g = cs16_mem_model_i.trace[i];
      if (g[24]) g[7:0] = 8'h00;
      if (g !== exq[i]) begin
        err_count++;
        $display("FAIL %0t bus cycle %0d is %h expected %h", $time, i, g, exq[i]);
      end
    end
  endtask
  // classic single wishbone cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_stop(input logic v);
    int n;
    n = 0;
    while (stopped !== v && n < 400) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk(stopped, v);
  endtask
  task automatic ld(input logic [15:0] a, input logic [7:0] b[]);
    foreach (b[i]) cs16_mem_model_i.mem[a + i] = b[i];
  endtask
  // expected cycles: nf fetches, optional idle read, then high and low byte
  task automatic st(input int nf, input bit idl, input logic [15:0] ea, input logic [15:0] v);
    repeat (nf) begin
      exq.push_back({1'b1, pc, 8'h00});
      pc++;
    end
    if (idl) exq.push_back({1'b1, IDLE_ADDR, 8'h00});
    exq.push_back({1'b0, ea, v[15:8]});
    exq.push_back({1'b0, ea + 16'h0001, v[7:0]});
  endtask
  // one-byte opcode: two reads, pc advances by one
  task automatic op1;
    exq.push_back({1'b1, pc, 8'h00});
    exq.push_back({1'b1, pc + 16'h0001, 8'h00});
    pc++;
  endtask
  task automatic do_reset;
    NRST <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    NRST <= 1'b1;
    cs16_mem_model_i.trace.delete();
    exq.delete();
    n_xs = 0;
    n_iw = 0;
    stp_seen = 0;
  endtask
  // every store form but D indexed on X and Y indexed on Y back to back, then stop woken by masked pseudo nmi and irq
  task automatic t_stores;
    do_reset;
    ld(16'h0200, '{8'hDD, 8'h40, 8'h18, 8'hED, 8'h10, 8'hBF, 8'h12, 8'h34, 8'hEF, 8'h20,
      8'hCD, 8'hEF, 8'h30, 8'h18, 8'hDF, 8'h50, 8'h1A, 8'hEF, 8'h05, 8'h18, 8'hFF, 8'h12,
      8'h40, 8'hDF, 8'h60, 8'hFF, 8'h12, 8'h50, 8'hAF, 8'h08, 8'h18, 8'hAF, 8'h09, 8'hFD,
      8'h12, 8'h60, 8'h9F, 8'h70, 8'h4F, 8'hCF, 8'hCF, 8'hCF});
    wr(OFS_D, 32'h8001);
    wr(OFS_SP, 32'h0000);
    wr(OFS_X, 32'h0100);
    wr(OFS_Y, 32'h0300);
    wr(OFS_CCR, 32'h42);
    wr(OFS_PC, 32'h0200);
    wr(OFS_CTRL, 32'h1);
    wait_stop(1'b1);
    pseudo_nonmaskable_interrupt_n <= 1'b0;
    wait_stop(1'b0);
    pseudo_nonmaskable_interrupt_n <= 1'b1;
    wait_stop(1'b1);
    irq_n <= 1'b0;
    wait_stop(1'b0);
    irq_n <= 1'b1;
    wait_stop(1'b1);
    pc = 16'h0200;
    st(2, 0, 16'h0040, 16'h8001);
    st(3, 1, 16'h0310, 16'h8001);
    st(3, 0, 16'h1234, 16'h0000);
    st(2, 1, 16'h0120, 16'h0100);
    st(3, 1, 16'h0330, 16'h0100);
    st(3, 0, 16'h0050, 16'h0300);
    st(3, 1, 16'h0105, 16'h0300);
    st(4, 0, 16'h1240, 16'h0300);
    st(2, 0, 16'h0060, 16'h0100);
    st(3, 0, 16'h1250, 16'h0100);
    st(2, 1, 16'h0108, 16'h0000);
    st(3, 1, 16'h0309, 16'h0000);
    st(3, 0, 16'h1260, 16'h8001);
    st(2, 0, 16'h0070, 16'h0000);
    repeat (4) op1;
    chk_trace(exq.size());
    chk(cs16_mem_model_i.trace.size(), exq.size());
    chk(n_xs, 0);
    chk(n_iw, 1);
    rchk(OFS_CCR, 32'h44);
    rchk(OFS_D, 32'h8001);
    rchk(OFS_SP, 32'h0000);
    rchk(OFS_X, 32'h0100);
    rchk(OFS_Y, 32'h0300);
  endtask
  // stop with the disable bit set runs on like a no-operation
  task automatic t_nostop;
    int k;
    do_reset;
    ld(16'h0300, '{8'hDD, 8'h40, 8'hCF, 8'hCF, 8'hCF});
    wr(OFS_D, 32'h8001);
    wr(OFS_PC, 32'h0300);
    wr(OFS_CTRL, 32'h1);
    k = 0;
    while (cs16_mem_model_i.trace.size() < 8 && k < 400) begin
      @(posedge SYS_CLK);
      k++;
    end
    pc = 16'h0300;
    st(2, 0, 16'h0040, 16'h8001);
    op1;
    op1;
    chk_trace(8);
    chk(stp_seen, 0);
    rchk(OFS_CCR, 32'hD8);
  endtask
  // masked irq keeps standby; pseudo nmi with its mask clear goes to stacking
  task automatic t_wake;
    do_reset;
    ld(16'h0310, '{8'hCF});
    wr(OFS_CCR, 32'h10);
    wr(OFS_PC, 32'h0310);
    wr(OFS_CTRL, 32'h1);
    wait_stop(1'b1);
    irq_n <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    chk(stopped, 1'b1);
    rchk(OFS_STATUS, 32'h0B);
    irq_n <= 1'b1;
    pseudo_nonmaskable_interrupt_n <= 1'b0;
    wait_stop(1'b0);
    pseudo_nonmaskable_interrupt_n <= 1'b1;
    repeat (BUS_DIV + 1) @(posedge SYS_CLK);
    chk(n_xs, 1);
    chk(n_iw, 0);
    rchk(OFS_CCR, 32'h10);
  endtask
  initial begin
    t_stores;
    t_nostop;
    t_wake;
    test_done;
  end
endmodule // cs16_core_bench
`default_nettype wire
